// [include/ffz_pkg.sv]
// Constants, register map and state codes for the freeze mode entry controller
package ffz_pkg;

  // Pad bank size
  localparam int NUM_PADS = 8;
  localparam int KIND_W = 2;

  // Clock and timing figures
  localparam int CLK_FREQ_MHZ = 200;
  localparam int ENTRY_TIME_US = 1;
  localparam int EXIT_TIME_US = 1;
  localparam int PLL_STOP_TIME_US = 1;
  localparam int ENTRY_LIMIT_CYCLES = ENTRY_TIME_US * CLK_FREQ_MHZ;
  localparam int EXIT_LIMIT_CYCLES = EXIT_TIME_US * CLK_FREQ_MHZ;
  localparam int PLL_STOP_LIMIT_CYCLES = PLL_STOP_TIME_US * CLK_FREQ_MHZ;
  // Two cycles are kept back for the state register and the pad register stage
  localparam int ENTRY_SETTLE_CYCLES = ENTRY_LIMIT_CYCLES - 2;
  localparam int EXIT_SETTLE_CYCLES = EXIT_LIMIT_CYCLES - 2;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] ENTRY_LAST = CNT_W'(ENTRY_SETTLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] EXIT_LAST = CNT_W'(EXIT_SETTLE_CYCLES - 1);

  // Register bus
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_PAD_KIND = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_PULL_EN = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_PULL_UP = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_FREEZE_COUNT = 5'h14;

  // Field positions
  localparam int CTRL_GATE_MACRO_BIT = 0;
  localparam int STATUS_STATE_LSB = 0;
  localparam int STATUS_REQ_N_BIT = 4;
  localparam int STATUS_LSE_BIT = 5;
  localparam int STATUS_PLL_RUN_BIT = 6;
  localparam int STATUS_ABORT_BIT = 7;
  localparam int COUNT_W = 16;

  // Reset values
  localparam logic CTRL_GATE_MACRO_RST = 1'b0;
  localparam logic [NUM_PADS*KIND_W-1:0] PAD_KIND_RST = 16'h0000;
  localparam logic [NUM_PADS-1:0] PULL_EN_RST = 8'h00;
  localparam logic [NUM_PADS-1:0] PULL_UP_RST = 8'h00;

  // Buffer kinds per pad
  localparam logic [KIND_W-1:0] KIND_INPUT = 2'h0;
  localparam logic [KIND_W-1:0] KIND_OUTPUT = 2'h1;
  localparam logic [KIND_W-1:0] KIND_BIDIR = 2'h2;

  typedef enum logic [3:0] {
    FFZ_NORMAL = 4'b0001,
    FFZ_ENTERING = 4'b0010,
    FFZ_FROZEN = 4'b0100,
    FFZ_EXITING = 4'b1000
  } ffz_state_t;

endpackage

// [hdl/ffz_pad_cell.sv]
// One I/O pad state cell: normal pass-through and freeze-time pad state
`timescale 1ns/1ps
`default_nettype none
module ffz_pad_cell
  import ffz_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic frozen,
  input wire logic [ffz_pkg::KIND_W-1:0] kind,
  input wire logic pull_en,
  input wire logic pull_up,
  input wire logic core_out,
  input wire logic core_oe,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pad_pull_en,
  output logic pad_pull_up,
  output logic core_in
);
  logic pad_out_r, pad_out_nxt;
  logic pad_oe_r, pad_oe_nxt;
  logic pull_en_r, pull_en_nxt;
  logic pull_up_r, pull_up_nxt;
  logic core_in_r, core_in_nxt;
  logic drive_req;

  always_comb begin
    // Bidirectional buffer acts as output when its enable is high, else as input
    if (kind == KIND_OUTPUT) begin
      drive_req = 1'b1;
    end else if (kind == KIND_BIDIR) begin
      drive_req = core_oe;
    end else begin
      drive_req = 1'b0;
    end
    pad_out_nxt = core_out;
    pull_en_nxt = pull_en;
    pull_up_nxt = pull_up;
    if (frozen) begin
      pad_oe_nxt = 1'b0;
      core_in_nxt = 1'b1;
    end else begin
      pad_oe_nxt = drive_req;
      core_in_nxt = pad_in;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pad_out_r <= 1'b0;
      pad_oe_r <= 1'b0;
      pull_en_r <= 1'b0;
      pull_up_r <= 1'b0;
      core_in_r <= 1'b1;
    end else begin
      pad_out_r <= pad_out_nxt;
      pad_oe_r <= pad_oe_nxt;
      pull_en_r <= pull_en_nxt;
      pull_up_r <= pull_up_nxt;
      core_in_r <= core_in_nxt;
    end
  end

  assign pad_out = pad_out_r;
  assign pad_oe = pad_oe_r;
  assign pad_pull_en = pull_en_r;
  assign pad_pull_up = pull_up_r;
  assign core_in = core_in_r;
endmodule
`default_nettype wire

// [hdl/ffz_freeze_ctrl.sv]
// Freeze mode entry and exit controller with pad state control and register slave
//
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Gated variant freezes only with request pin low and enable high together.
// - Enable input affects nothing but gating of freeze entry.
// - Request pin asserts low; enable input asserts high.
// - Enable input takes part only in the gated variant.
// - Pin-only variant: pin deasserted runs normally, asserted means frozen.
// - Gated variant stays normal if pin deasserted, or pin asserted without enable.
// - Frozen inputs and bidirectional inputs present constant high to core.
// - Pads without weak pull go high impedance when frozen.
// - Pads with weak pull keep that pull while frozen.
// - Gated entry completes within 1 us of both conditions asserted.
// - Exit completes within 1 us of pin deasserted, enable ignored.
// - Loop clocks stop within 1 us of entry condition becoming true.
module ffz_freeze_ctrl
  import ffz_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ffz_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ffz_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [ffz_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic freeze_request_n,
  input wire logic low_static_enable,
  input wire logic [ffz_pkg::NUM_PADS-1:0] pad_in,
  input wire logic [ffz_pkg::NUM_PADS-1:0] core_out,
  input wire logic [ffz_pkg::NUM_PADS-1:0] core_oe,
  output logic [ffz_pkg::NUM_PADS-1:0] pad_out,
  output logic [ffz_pkg::NUM_PADS-1:0] pad_oe,
  output logic [ffz_pkg::NUM_PADS-1:0] pad_pull_en,
  output logic [ffz_pkg::NUM_PADS-1:0] pad_pull_up,
  output logic [ffz_pkg::NUM_PADS-1:0] core_in,
  output logic pll_clk_enable,
  output logic freeze_active
);
  import ffz_pkg::*;

  // Freeze sequencer state
  ffz_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic pll_run_r, pll_run_nxt;
  logic frozen_r, frozen_nxt;
  logic entry_cond;
  logic request_on;
  logic gate_on;
  logic abort_evt;
  logic enter_evt;

  // Register file state
  logic gate_macro_r, gate_macro_nxt;
  logic [NUM_PADS*KIND_W-1:0] pad_kind_r, pad_kind_nxt;
  logic [NUM_PADS-1:0] pull_en_r, pull_en_nxt;
  logic [NUM_PADS-1:0] pull_up_r, pull_up_nxt;
  logic abort_r, abort_nxt;
  logic [COUNT_W-1:0] freeze_count_r, freeze_count_nxt;

  // Bus slave state
  logic ack_r, ack_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic req;
  logic wr_go;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] be_mask;

  // Entry condition
  always_comb begin
    request_on = ~freeze_request_n;
    gate_on = low_static_enable;
    // Enable input only gates entry and only in the gated variant
    if (gate_macro_r) begin
      entry_cond = request_on & gate_on;
    end else begin
      entry_cond = request_on;
    end
  end

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    abort_evt = 1'b0;
    enter_evt = 1'b0;
    case (state_r)
      FFZ_NORMAL: begin
        cnt_nxt = '0;
        if (entry_cond) begin
          state_nxt = FFZ_ENTERING;
        end
      end
      FFZ_ENTERING: begin
        // A dropped condition mid-entry returns to normal instead of freezing
        if (!entry_cond) begin
          state_nxt = FFZ_NORMAL;
          cnt_nxt = '0;
          abort_evt = 1'b1;
        end else if (cnt_r == ENTRY_LAST) begin
          state_nxt = FFZ_FROZEN;
          cnt_nxt = '0;
          enter_evt = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      FFZ_FROZEN: begin
        cnt_nxt = '0;
        // Exit depends on the pin alone
        if (freeze_request_n) begin
          state_nxt = FFZ_EXITING;
        end
      end
      FFZ_EXITING: begin
        // Exit always runs to completion before the pin is looked at again
        if (cnt_r == EXIT_LAST) begin
          state_nxt = FFZ_NORMAL;
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      default: begin
        state_nxt = FFZ_NORMAL;
        cnt_nxt = '0;
      end
    endcase
    // Loop clocks stop as soon as entry starts, well inside the limit
    pll_run_nxt = (state_nxt == FFZ_NORMAL);
    frozen_nxt = (state_nxt == FFZ_FROZEN) || (state_nxt == FFZ_EXITING);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= FFZ_NORMAL;
      cnt_r <= '0;
      pll_run_r <= 1'b1;
      frozen_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pll_run_r <= pll_run_nxt;
      frozen_r <= frozen_nxt;
    end
  end

  assign pll_clk_enable = pll_run_r;
  assign freeze_active = frozen_r;

  // Pad cells
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PADS; gi++) begin : g_pad
      ffz_pad_cell u_pad (
        .clk(clk),
        .sys_rst(sys_rst),
        .frozen(frozen_r),
        .kind(pad_kind_r[gi*KIND_W +: KIND_W]),
        .pull_en(pull_en_r[gi]),
        .pull_up(pull_up_r[gi]),
        .core_out(core_out[gi]),
        .core_oe(core_oe[gi]),
        .pad_in(pad_in[gi]),
        .pad_out(pad_out[gi]),
        .pad_oe(pad_oe[gi]),
        .pad_pull_en(pad_pull_en[gi]),
        .pad_pull_up(pad_pull_up[gi]),
        .core_in(core_in[gi])
      );
    end
  endgenerate

  // Bus slave: one wait cycle on every access, answer on the second
  always_comb begin
    req = avs_read | avs_write;
    avs_waitrequest = req & ~ack_r;
    wr_go = avs_write & ack_r;
    ack_nxt = req & ~ack_r;
    be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    rd_word = '0;
    if (avs_address == OFS_CTRL) begin
      rd_word[CTRL_GATE_MACRO_BIT] = gate_macro_r;
    end else if (avs_address == OFS_PAD_KIND) begin
      rd_word[NUM_PADS*KIND_W-1:0] = pad_kind_r;
    end else if (avs_address == OFS_PULL_EN) begin
      rd_word[NUM_PADS-1:0] = pull_en_r;
    end else if (avs_address == OFS_PULL_UP) begin
      rd_word[NUM_PADS-1:0] = pull_up_r;
    end else if (avs_address == OFS_STATUS) begin
      rd_word[STATUS_STATE_LSB +: 4] = state_r;
      rd_word[STATUS_REQ_N_BIT] = freeze_request_n;
      rd_word[STATUS_LSE_BIT] = low_static_enable;
      rd_word[STATUS_PLL_RUN_BIT] = pll_run_r;
      rd_word[STATUS_ABORT_BIT] = abort_r;
    end else if (avs_address == OFS_FREEZE_COUNT) begin
      rd_word[COUNT_W-1:0] = freeze_count_r;
    end else begin
      rd_word = '0;
    end
    if (avs_read && !ack_r) begin
      rdata_nxt = rd_word;
    end else begin
      rdata_nxt = rdata_r;
    end
  end

  // Register writes
  always_comb begin
    gate_macro_nxt = gate_macro_r;
    pad_kind_nxt = pad_kind_r;
    pull_en_nxt = pull_en_r;
    pull_up_nxt = pull_up_r;
    abort_nxt = abort_r;
    freeze_count_nxt = freeze_count_r;
    if (wr_go) begin
      if (avs_address == OFS_CTRL) begin
        if (avs_byteenable[0]) begin
          // Variant changes take effect on the next evaluation of the entry condition
          gate_macro_nxt = avs_writedata[CTRL_GATE_MACRO_BIT];
        end
      end else if (avs_address == OFS_PAD_KIND) begin
        pad_kind_nxt = (pad_kind_r & ~be_mask[NUM_PADS*KIND_W-1:0]) |
                       (avs_writedata[NUM_PADS*KIND_W-1:0] & be_mask[NUM_PADS*KIND_W-1:0]);
      end else if (avs_address == OFS_PULL_EN) begin
        if (avs_byteenable[0]) begin
          pull_en_nxt = avs_writedata[NUM_PADS-1:0];
        end
      end else if (avs_address == OFS_PULL_UP) begin
        if (avs_byteenable[0]) begin
          pull_up_nxt = avs_writedata[NUM_PADS-1:0];
        end
      end else if (avs_address == OFS_STATUS) begin
        if (avs_byteenable[0] && avs_writedata[STATUS_ABORT_BIT]) begin
          abort_nxt = 1'b0;
        end
      end else begin
        abort_nxt = abort_r;
      end
    end
    // Hardware set beats a software clear in the same cycle
    if (abort_evt) begin
      abort_nxt = 1'b1;
    end
    if (enter_evt) begin
      freeze_count_nxt = freeze_count_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gate_macro_r <= CTRL_GATE_MACRO_RST;
      pad_kind_r <= PAD_KIND_RST;
      pull_en_r <= PULL_EN_RST;
      pull_up_r <= PULL_UP_RST;
      abort_r <= 1'b0;
      freeze_count_r <= '0;
      ack_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      gate_macro_r <= gate_macro_nxt;
      pad_kind_r <= pad_kind_nxt;
      pull_en_r <= pull_en_nxt;
      pull_up_r <= pull_up_nxt;
      abort_r <= abort_nxt;
      freeze_count_r <= freeze_count_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_readdata = rdata_r;
endmodule
`default_nettype wire

// [sim/ffz_core_model.sv]
// Partner model: freeze pin driver and user core logic
`timescale 1ns/1ps
`default_nettype none
module ffz_core_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic want_freeze,
  input wire logic safe_done,
  input wire logic freeze_active,
  output logic freeze_request_n,
  output logic low_static_enable
);
  logic active_r;
  logic lock_r;
  always_ff @(posedge clk) begin
    active_r <= freeze_active;
    freeze_request_n <= sys_rst | ~want_freeze;
    if (sys_rst || !safe_done) begin
      lock_r <= 1'b0;
    end else if (active_r && !freeze_active) begin
      lock_r <= 1'b1;
    end
  end
  // Raised only once core is safe, then held until core withdraws or a freeze exits
  assign low_static_enable = safe_done & ~lock_r;
endmodule
`default_nettype wire

// [sim/ffz_freeze_ctrl_properties.sv]
// Port assertions for the freeze controller
`timescale 1ns/1ps
`default_nettype none
module ffz_freeze_ctrl_properties
  import ffz_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ffz_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ffz_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic freeze_request_n,
  input wire logic low_static_enable,
  input wire logic [ffz_pkg::NUM_PADS-1:0] pad_oe,
  input wire logic [ffz_pkg::NUM_PADS-1:0] pad_pull_en,
  input wire logic [ffz_pkg::NUM_PADS-1:0] pad_pull_up,
  input wire logic [ffz_pkg::NUM_PADS-1:0] core_in,
  input wire logic pll_clk_enable,
  input wire logic freeze_active
);
  import ffz_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic gate_r;
  logic gate_nxt;
  logic entry_cond;
  // Shadow of the variant bit, the only register that steers entry
  always_comb begin
    gate_nxt = gate_r;
    if (avs_write && !avs_waitrequest && avs_address == OFS_CTRL && avs_byteenable[0]) begin
      gate_nxt = avs_writedata[0];
    end
  end
  always_ff @(posedge clk) begin
    gate_r <= sys_rst ? 1'b0 : gate_nxt;
  end
  assign entry_cond = !freeze_request_n && (!gate_r || low_static_enable);
  sequence s_start;
    !freeze_active && pll_clk_enable && entry_cond;
  endsequence
  sequence s_begun;
    $fell(pll_clk_enable) && !freeze_active;
  endsequence
  a_entry_starts: assert property (s_start |=> !pll_clk_enable)
    else $error("entry did not start");
  a_no_entry: assert property (!freeze_active && !entry_cond |=> pll_clk_enable)
    else $error("left normal without entry condition");
  a_entry_time: assert property (s_begun |-> ##[1:199] (freeze_active || pll_clk_enable))
    else $error("entry too slow");
  a_pll_frozen: assert property (freeze_active |-> !pll_clk_enable)
    else $error("loop clocks run while frozen");
  a_frozen_pads: assert property (freeze_active && $past(freeze_active) |-> pad_oe == '0 && core_in == '1)
    else $error("pads not frozen");
  a_pull_hold: assert property (freeze_active |-> $stable(pad_pull_en) && $stable(pad_pull_up))
    else $error("pull changed while frozen");
  a_exit_time: assert property (freeze_active && freeze_request_n |-> ##[1:199] !freeze_active)
    else $error("exit too slow");
  a_exit_pll: assert property ($fell(freeze_active) |-> pll_clk_enable)
    else $error("loop clocks not back at exit");
  a_bus_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
endmodule
bind ffz_freeze_ctrl ffz_freeze_ctrl_properties prop_u (.clk, .sys_rst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_waitrequest, .freeze_request_n, .low_static_enable, .pad_oe,
  .pad_pull_en, .pad_pull_up, .core_in, .pll_clk_enable, .freeze_active);
`default_nettype wire

// [sim/ffz_freeze_ctrl_test.sv]
// Self-checking bench for the freeze controller
`timescale 1ns/1ps
`default_nettype none
module ffz_freeze_ctrl_test;
  import ffz_pkg::*;
  logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, pll_clk_enable, freeze_active;
  logic freeze_request_n, low_static_enable, want_freeze, safe_done;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, seed, q;
  logic [3:0] avs_byteenable;
  logic [7:0] pad_in, core_out, core_oe, pad_out, pad_oe, pad_pull_en, pad_pull_up, core_in, pen, pup;
  logic [15:0] kind;
  int mismatches, tests_run, n, ents;
  ffz_freeze_ctrl dut_u (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .freeze_request_n, .low_static_enable, .pad_in, .core_out, .core_oe,
    .pad_out, .pad_oe, .pad_pull_en, .pad_pull_up, .core_in, .pll_clk_enable, .freeze_active);
  ffz_core_model far_u (.clk, .sys_rst, .want_freeze, .safe_done, .freeze_active, .freeze_request_n,
    .low_static_enable);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] exp_oe(input logic [15:0] k, input logic [7:0] oe, input logic fz);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = !fz && (k[2*i+:2] == KIND_OUTPUT || (k[2*i+:2] == KIND_BIDIR && oe[i]));
    return r;
  endfunction
  task automatic end_of_test;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_time(input int got, input int lim);
    tests_run++;
    if (got > lim) begin
      mismatches++;
      $display("unexpected at %0t: took %0d cycles", $time, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
    if (k >= 20) begin
      mismatches++;
      end_of_test();
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // Pin passes the model's register, plus one edge to see the flag
  task automatic wait_fa(input logic lvl, input int lim);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (freeze_active !== lvl && n < 400);
    chk_time(n, lim + 2);
    if (n >= 400) end_of_test();
  endtask
  task automatic padchk(input logic fz, input logic wiggle);
    seed = xs(seed);
    {pad_in, core_out, core_oe} <= seed[23:0];
    if (wiggle) safe_done <= seed[24];
    repeat (2) @(posedge clk);
    chk(32'(pad_oe), 32'(exp_oe(kind, core_oe, fz)));
    chk(32'(core_in), fz ? 32'hFF : 32'(pad_in));
    chk({16'h0, pad_pull_en, pad_pull_up}, {16'h0, pen, pup});
    if (!fz) chk(32'(pad_out), 32'(core_out));
  endtask
  initial begin
    sys_rst = 1'b1;
    {avs_read, avs_write, want_freeze, safe_done} = 4'h0;
    {avs_address, avs_writedata, pad_in, core_out, core_oe} = '0;
    {kind, pen, pup} = '0;
    avs_byteenable = 4'hF;
    seed = 32'hB457;
    {mismatches, tests_run, ents} = '0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 4; i++) rd(5'(4 * i), 32'h0);
    rd(OFS_STATUS, 32'h51);
    bus(1'b1, 5'h18, 32'hFFFFFFFF);
    rd(5'h18, 32'h0);
    repeat (3) begin
      seed = xs(seed);
      {pup, pen, kind} = seed;
      bus(1'b1, OFS_PAD_KIND, {16'h0, kind});
      bus(1'b1, OFS_PULL_EN, {24'h0, pen});
      bus(1'b1, OFS_PULL_UP, {24'h0, pup});
      padchk(1'b0, 1'b1);
      want_freeze <= 1'b1;
      wait_fa(1'b1, ENTRY_LIMIT_CYCLES);
      chk(32'(pll_clk_enable), 32'h0);
      padchk(1'b1, 1'b1);
      want_freeze <= 1'b0;
      wait_fa(1'b0, EXIT_LIMIT_CYCLES);
      ents++;
    end
    safe_done <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h1);
    want_freeze <= 1'b1;
    repeat (300) @(posedge clk);
    chk(32'({pll_clk_enable, freeze_active}), 32'h2);
    want_freeze <= 1'b0;
    safe_done <= 1'b1;
    repeat (300) @(posedge clk);
    chk(32'({pll_clk_enable, freeze_active}), 32'h2);
    want_freeze <= 1'b1;
    wait_fa(1'b1, ENTRY_LIMIT_CYCLES);
    ents++;
    want_freeze <= 1'b0;
    wait_fa(1'b0, EXIT_LIMIT_CYCLES);
    want_freeze <= 1'b1;
    repeat (300) @(posedge clk);
    chk(32'({pll_clk_enable, freeze_active}), 32'h2);
    want_freeze <= 1'b0;
    safe_done <= 1'b0;
    @(posedge clk);
    safe_done <= 1'b1;
    want_freeze <= 1'b1;
    repeat (50) @(posedge clk);
    safe_done <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'({pll_clk_enable, freeze_active}), 32'h2);
    rd(OFS_STATUS, 32'hC1);
    want_freeze <= 1'b0;
    bus(1'b1, OFS_STATUS, 32'h80);
    rd(OFS_STATUS, 32'h51);
    rd(OFS_FREEZE_COUNT, 32'(ents));
    bus(1'b1, OFS_FREEZE_COUNT, 32'hFFFF);
    rd(OFS_FREEZE_COUNT, 32'(ents));
    end_of_test();
  end
endmodule
`default_nettype wire
